// ---- rtl/index_edge.sv ----
`timescale 1ns/1ps
module index_edge
   import stall_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic index_pulse_i,
   index_evt_if.src evt
);

   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
   } edge_state_t;

   edge_state_t st_r;
   edge_state_t st_nxt;

   // Two stages bring the pin into the clock domain; only the second is compared.
   always_comb begin
      st_nxt = st_r;
      st_nxt.meta = index_pulse_i;
      st_nxt.sync = st_r.meta;
      st_nxt.last = st_r.sync;
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         // Stages start high so a mark already under the sensor is no crossing.
         st_r <= {3{INDEX_RESET_LEVEL}};
      end else begin
         st_r <= st_nxt;
      end
   end

   // One pulse on each rising edge of the synchronised index signal.
   assign evt.index_hit = st_r.sync & ~st_r.last;

endmodule

// ---- rtl/index_evt_if.sv ----
`timescale 1ns/1ps
interface index_evt_if;
   logic index_hit;

   modport src (output index_hit);
   modport snk (input index_hit);
endinterface

// ---- rtl/stall_pkg.sv ----
package stall_pkg;

   // Pole pairs in one shaft revolution; one pole pair is a fiftieth of a turn.
   localparam int unsigned POLE_PAIRS_PER_REV = 50;
   // Default field steps per pole pair, one electrical period of the field.
   localparam int unsigned STEPS_PER_POLE_PAIR = 4;
   // Width of the drive control word and the fault reset bit within it.
   localparam int unsigned DRIVE_CTRL_W = 16;
   localparam int unsigned FAULT_RESET_BIT = 3;
   // Width of the persistent settings word and its stall monitor bit.
   localparam int unsigned SETTINGS_W = 16;
   localparam int unsigned MONITOR_EN_BIT = 0;
   // Value the stall monitor bit should hold after the settings are restored.
   localparam logic MONITOR_EN_DEFAULT = 1'b1;
   // Value of every flag after reset.
   localparam logic FLAG_RESET = 1'b0;
   // Level the index synchroniser stages take at reset.
   localparam logic INDEX_RESET_LEVEL = 1'b1;

   // Detector states, Gray coded along off, waiting, armed.
   typedef enum logic [1:0] {
      DET_OFF   = 2'b00,
      DET_WAIT  = 2'b01,
      DET_ARMED = 2'b11
   } det_state_t;

endpackage

// ---- rtl/stepper_stall_detector.sv ----
`timescale 1ns/1ps
// Behaviour
// RQ1: While moving, capture field angle at each index pulse; mismatch to reference is stall.
// RQ2: Displacement counts whole pole pairs, fiftieth of a turn; one or more is a stall.
// RQ3: Each power stage switch-on starts disarmed and drops the old reference angle.
// RQ4: Arm on first index crossing after power-on; evaluate stalls only from then.
// RQ5: A stall while braking shows at the next index crossing, maybe next movement.
// RQ6: Applications travelling under one revolution must not rely on stall detection.
// RQ7: Standstill index edges are ignored; shaft rotation then waits for the next movement.
// RQ8: Settings bit zero enables stall monitoring; one enables, default enabled.
// RQ9: Latched fault bit holds until fault reset, drive control word bit three.
// RQ10: A stall sets the live and latched fault bits in the same cycle.
module stepper_stall_detector
   import stall_pkg::*;
#(
   parameter int unsigned STEPS_PP = STEPS_PER_POLE_PAIR,
   parameter int unsigned POLE_PAIRS = POLE_PAIRS_PER_REV,
   parameter int unsigned STEPS_REV = STEPS_PP * POLE_PAIRS,
   parameter int unsigned POS_W = $clog2(STEPS_REV)
)
(
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic power_on_i,
   input wire logic motor_moving_i,
   input wire logic [POS_W-1:0] field_pos_i,
   input wire logic index_pulse_i,
   input wire logic [stall_pkg::SETTINGS_W-1:0] settings_word_i,
   input wire logic [stall_pkg::DRIVE_CTRL_W-1:0] drive_control_word_i,
   output logic armed_o,
   output logic live_fault_signals_o,
   output logic latched_fault_signals_o
);

   typedef struct packed {
      det_state_t state;
      logic [POS_W-1:0] ref_pos;
      logic live;
      logic latched;
   } det_regs_t;

   localparam logic [POS_W-1:0] STEPS_PP_W = POS_W'(STEPS_PP);
   localparam logic [POS_W:0] STEPS_REV_W = (POS_W+1)'(STEPS_REV);

   det_regs_t st_r;
   det_regs_t st_nxt;
   logic stall_monitor_enable;
   logic fault_reset;
   logic [POS_W:0] diff;
   logic slipped;
   logic evaluate;
   logic stall_hit;

   index_evt_if evt ();

   // Synchronise the index pin and turn its rising edge into a single pulse.
   index_edge u_index_edge (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .index_pulse_i(index_pulse_i),
      .evt(evt)
   );

   // RQ8: monitor enable bit.
   assign stall_monitor_enable = settings_word_i[MONITOR_EN_BIT];
   assign fault_reset = drive_control_word_i[FAULT_RESET_BIT];

   // RQ2: distance modulo one turn.
   always_comb begin
      if (field_pos_i >= st_r.ref_pos) begin
         diff = {1'b0, field_pos_i} - {1'b0, st_r.ref_pos};
      end else begin
         diff = {1'b0, field_pos_i} + STEPS_REV_W - {1'b0, st_r.ref_pos};
      end
   end

   // RQ2: one pole pair either way.
   assign slipped = (diff >= {1'b0, STEPS_PP_W}) && (diff <= STEPS_REV_W - {1'b0, STEPS_PP_W});

   // RQ7: standstill edges are ignored.
   assign evaluate = evt.index_hit & motor_moving_i & power_on_i;
   // RQ1: compare on each moving index.
   assign stall_hit = evaluate && (st_r.state == DET_ARMED) && stall_monitor_enable && slipped;

   // Next state of the detector and the fault flags.
   always_comb begin
      st_nxt = st_r;
      case (st_r.state)
         DET_OFF: begin
            if (power_on_i) begin
               st_nxt.state = DET_WAIT;
            end
         end
         DET_WAIT: begin
            // RQ4: first crossing arms.
            if (!power_on_i) begin
               st_nxt.state = DET_OFF;
            end else if (evaluate) begin
               st_nxt.state = DET_ARMED;
               st_nxt.ref_pos = field_pos_i;
            end
         end
         DET_ARMED: begin
            // RQ5: late braking stalls surface here.
            if (!power_on_i) begin
               st_nxt.state = DET_OFF;
            end else if (evaluate && stall_monitor_enable) begin
               st_nxt.live = slipped;
            end
         end
         default: begin
            st_nxt.state = DET_OFF;
         end
      endcase
      // RQ3: switch-off disarms and drops the reference.
      if (!power_on_i) begin
         st_nxt.ref_pos = '0;
         st_nxt.live = FLAG_RESET;
      end
      if (!stall_monitor_enable) begin
         st_nxt.live = FLAG_RESET;
      end
      // RQ9: sticky until fault reset; a new stall wins over the clear.
      if (fault_reset) begin
         st_nxt.latched = FLAG_RESET;
      end
      // RQ10: both fault bits together.
      if (stall_hit) begin
         st_nxt.live = 1'b1;
         st_nxt.latched = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         st_r.state <= DET_OFF;
         st_r.ref_pos <= '0;
         st_r.live <= FLAG_RESET;
         st_r.latched <= FLAG_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Status outputs straight from the state register.
   assign armed_o = (st_r.state == DET_ARMED);
   assign live_fault_signals_o = st_r.live;
   assign latched_fault_signals_o = st_r.latched;

   // Checks on the detector behaviour.
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   chk_stall_sets_live: assert property (stall_hit |=> live_fault_signals_o) // RQ1
      else $error("stall did not raise the live fault");

   chk_half_pp_no_stall: assert property (evaluate && armed_o && !slipped && !stall_hit
      |=> !live_fault_signals_o) // RQ2
      else $error("sub pole pair shift raised a fault");

   chk_off_disarms: assert property (!power_on_i |=> !armed_o && st_r.ref_pos == '0) // RQ3
      else $error("power off left the detector armed");

   chk_arm_first_index: assert property (st_r.state == DET_WAIT && evaluate
      |=> armed_o && st_r.ref_pos == $past(field_pos_i)) // RQ4
      else $error("first index crossing did not arm");

   chk_no_eval_unarmed: assert property (!armed_o |-> !stall_hit) // RQ4
      else $error("stall evaluated before arming");

   chk_only_at_index: assert property ($rose(latched_fault_signals_o) |->
      $past(evaluate)) // RQ5
      else $error("stall reported away from an index crossing");

   chk_standstill_quiet: assert property (!motor_moving_i |=> !$rose(live_fault_signals_o)) // RQ7
      else $error("stall raised at standstill");

   chk_monitor_off: assert property (!stall_monitor_enable |=> !live_fault_signals_o) // RQ8
      else $error("disabled monitor raised a fault");

   chk_latch_holds: assert property (latched_fault_signals_o && !fault_reset
      |=> latched_fault_signals_o) // RQ9
      else $error("latched fault dropped without fault reset");

   chk_set_beats_clear: assert property (stall_hit && fault_reset
      |=> latched_fault_signals_o) // RQ9
      else $error("fault reset swallowed a new stall");

   chk_both_bits: assert property (stall_hit |=> live_fault_signals_o && latched_fault_signals_o
      ##1 latched_fault_signals_o || $past(fault_reset)) // RQ10
      else $error("stall did not set both fault bits");

   // Power cycling, the held reference, pole pair slips, fault reset and the latch over standstill.
   chk_off_clears_live: assert property (!power_on_i |=> !live_fault_signals_o) // RQ3
      else $error("power off left the live fault set");

   chk_wait_after_on: assert property (st_r.state == DET_OFF && power_on_i
      |=> st_r.state == DET_WAIT) // RQ3
      else $error("power on did not start the wait for an index crossing");

   chk_armed_needs_power: assert property (armed_o |-> $past(power_on_i)) // RQ4
      else $error("detector armed without the power stage on");

   chk_ref_held: assert property (armed_o && power_on_i |=> $stable(st_r.ref_pos)) // RQ1
      else $error("reference angle moved after arming");

   chk_slip_sets_both: assert property (evaluate && armed_o && stall_monitor_enable
      && slipped |=> live_fault_signals_o && latched_fault_signals_o) // RQ2
      else $error("pole pair shift at an index crossing raised no fault");

   chk_clear_drops_latch: assert property (fault_reset && !stall_hit
      |=> !latched_fault_signals_o) // RQ9
      else $error("fault reset left the latched fault set");

   chk_still_holds_latch: assert property (!motor_moving_i && !fault_reset
      |=> $stable(latched_fault_signals_o)) // RQ7
      else $error("latched fault changed at standstill");

   // Cover points for the main scenarios.

   cov_arm: cover property (st_r.state == DET_WAIT ##1 armed_o);
   cov_stall: cover property (armed_o ##[1:1000] stall_hit);
   cov_reset_fault: cover property (latched_fault_signals_o ##1 fault_reset ##1
      !latched_fault_signals_o);
   cov_set_beats_clear: cover property (stall_hit && fault_reset);
   cov_monitor_off_slip: cover property (evaluate && armed_o && !stall_monitor_enable && slipped);

endmodule

// ---- tb/motor_model.sv ----
`timescale 1ns/1ps
module motor_model (
   input wire logic ref_clk_i,
   input wire logic turn_i,
   input wire logic [7:0] slip_i,
   output logic [7:0] field_pos_o,
   output logic index_pulse_o
);
   logic [15:0] shaft;
   initial field_pos_o = 8'h00;
   // The field advances one step a cycle while turning and wraps after a turn.
   always @(posedge ref_clk_i) begin
      if (turn_i) begin
         field_pos_o <= (field_pos_o == 8'hc7) ? 8'h00 : field_pos_o + 8'h01;
      end
   end
   // The shaft lags the field by whole slipped pole pairs of four steps.
   assign shaft = (16'(field_pos_o) + 16'h00c8 - 16'(slip_i) * 16'h0004) % 16'h00c8;
   // index follows the shaft alone, not turn
   // The sensor only fires where the shaft passes its mark.
   assign index_pulse_o = (shaft < 16'h0002);
endmodule

// ---- tb/stepper_stall_detector_test.sv ----
`timescale 1ns/1ps
module stepper_stall_detector_test;
   import stall_pkg::*;
   logic ref_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic power_on_i = 1'b0;
   logic moving = 1'b0;
   logic [15:0] settings = 16'h0001;
   logic [15:0] drive_ctrl = 16'h0000;
   logic [7:0] slip = 8'h00;
   logic [7:0] field_pos;
   logic index_pulse;
   logic armed;
   logic live;
   logic latched;
   int n_errors = 0;
   int n_checks = 0;
   // The clock toggles every 2.5 ns, half of its 5 ns period.
   always #2.5 ref_clk_i = ~ref_clk_i;
   motor_model motor (.ref_clk_i(ref_clk_i), .turn_i(moving), .slip_i(slip),
      .field_pos_o(field_pos), .index_pulse_o(index_pulse));
   stepper_stall_detector dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .power_on_i(power_on_i), .motor_moving_i(moving), .field_pos_i(field_pos),
      .index_pulse_i(index_pulse), .settings_word_i(settings),
      .drive_control_word_i(drive_ctrl), .armed_o(armed),
      .live_fault_signals_o(live), .latched_fault_signals_o(latched));
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask
   // Compares armed, live and latched at a settled point of the cycle.
   task automatic check_flags(input string name, input logic [2:0] exp);
      @(negedge ref_clk_i);
      n_checks++;
      if ({armed, live, latched} !== exp) begin
         n_errors++;
         $display("FAIL %s expected %b seen %b", name, exp, {armed, live, latched});
      end
      @(posedge ref_clk_i);
   endtask
   task automatic wait_armed();
      int i;
      i = 0;
      @(negedge ref_clk_i);
      while (armed !== 1'b1 && i < 220) begin
         @(negedge ref_clk_i);
         i++;
      end
      @(posedge ref_clk_i);
      if (i == 220) begin
         n_errors++;
         $display("FAIL armed expected 1 seen %b", armed);
         close_out();
      end
   endtask
   task automatic fault_reset();
      drive_ctrl <= 16'h0008;
      cyc(1);
      drive_ctrl <= 16'h0000;
   endtask
   task automatic t_arm();
      power_on_i <= 1'b1;
      moving <= 1'b1;
      check_flags("disarmed", 3'b000);
      wait_armed();
      cyc(420);
      check_flags("clean", 3'b100);
   endtask
   task automatic t_slip();
      slip <= 8'h01;
      cyc(210);
      check_flags("slip1", 3'b111);
      slip <= 8'h00;
      cyc(210);
      check_flags("held", 3'b101);
      fault_reset();
      check_flags("cleared", 3'b100);
      slip <= 8'h31;
      cyc(210);
      check_flags("slip49", 3'b111);
   endtask
   task automatic t_disable();
      slip <= 8'h00;
      cyc(210);
      fault_reset();
      settings <= 16'h0000;
      slip <= 8'h02;
      cyc(210);
      check_flags("off", 3'b100);
      settings <= 16'h0001;
      cyc(210);
      check_flags("on", 3'b111);
   endtask
   task automatic t_brake();
      slip <= 8'h00;
      cyc(210);
      fault_reset();
      moving <= 1'b0;
      cyc(4);
      slip <= 8'h03;
      cyc(300);
      check_flags("still", 3'b100);
      moving <= 1'b1;
      cyc(210);
      check_flags("next_move", 3'b111);
   endtask
   task automatic t_power();
      power_on_i <= 1'b0;
      cyc(2);
      check_flags("pwr_off", 3'b001);
      power_on_i <= 1'b1;
      wait_armed();
      cyc(420);
      check_flags("new_ref", 3'b101);
      fault_reset();
      check_flags("reset_end", 3'b100);
   endtask
   // A stall in a cycle where fault reset is held still sets the latched bit.
   task automatic t_race();
      int i;
      i = 0;
      slip <= 8'h04;
      drive_ctrl <= 16'h0008;
      do begin
         @(posedge ref_clk_i);
         #1;
         i++;
      end while (live !== 1'b1 && i < 220);
      if (live !== 1'b1) begin
         n_errors++;
         $display("FAIL live expected 1 seen %b", live);
         close_out();
      end
      check_flags("race_set", 3'b111);
      check_flags("race_clear", 3'b110);
      drive_ctrl <= 16'h0000;
   endtask
   // Main sequence: reset, then every scenario in turn.
   initial begin
      cyc(6);
      sys_rst_i <= 1'b0;
      check_flags("reset", 3'b000);
      t_arm();
      t_slip();
      t_disable();
      t_brake();
      t_power();
      t_race();
      close_out();
   end
endmodule
